// *** rsf_defines.svh ***
// Command codes, state codes, reset values and timing counts of the radio state controller
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH
`define RSF_CMD_POWER_UP 8'h02
`define RSF_CMD_SET_FRR 8'h11
`define RSF_CMD_INT_STATUS 8'h20
`define RSF_CMD_START_RX 8'h32
`define RSF_CMD_CHANGE_STATE 8'h34
`define RSF_CMD_READ_CTS 8'h44
`define RSF_CMD_FRR_A 8'h50
`define RSF_CMD_FRR_B 8'h51
`define RSF_CMD_FRR_C 8'h53
`define RSF_CMD_FRR_D 8'h57
`define RSF_CTS_READY 8'hff
`define RSF_CTS_BUSY 8'h00
`define RSF_SC_STANDBY 8'h01
`define RSF_SC_READY 8'h04
`define RSF_SC_RX_TUNE 8'h05
`define RSF_SC_RX 8'h06
`define RSF_FRR_CFG_RST 8'he4
`define RSF_CLK_NS 100
`define RSF_CYC_UP(t) (((t) + `RSF_CLK_NS - 1) / `RSF_CLK_NS)
`define RSF_T_LDO_NS 10000
`define RSF_T_XTAL_NS 308000
`define RSF_T_PLL_NS 20000
`define RSF_T_VCO_NS 40000
`define RSF_T_SETTLE_NS 50000
`define RSF_T_FE_NS 10000
`define RSF_T_MODEM_NS 2000
`define RSF_T_CMD_NS 20000
`define RSF_T_POR_NS 15000000
`define RSF_C_LDO 18'(`RSF_CYC_UP(`RSF_T_LDO_NS))
`define RSF_C_XTAL 18'(`RSF_CYC_UP(`RSF_T_XTAL_NS))
`define RSF_C_PLL 18'(`RSF_CYC_UP(`RSF_T_PLL_NS))
`define RSF_C_VCO 18'(`RSF_CYC_UP(`RSF_T_VCO_NS))
`define RSF_C_SETTLE 18'(`RSF_CYC_UP(`RSF_T_SETTLE_NS))
`define RSF_C_FE 18'(`RSF_CYC_UP(`RSF_T_FE_NS))
`define RSF_C_MODEM 18'(`RSF_CYC_UP(`RSF_T_MODEM_NS))
`define RSF_C_CMD 12'(`RSF_CYC_UP(`RSF_T_CMD_NS))
`define RSF_C_POR `RSF_CYC_UP(`RSF_T_POR_NS)
`endif

// *** rsf_pkg.sv ***
// Types shared by the radio state controller
`default_nettype none
package rsf_pkg;
	typedef enum logic [2:0] {st_shutdown, st_standby, st_sleep, st_spi_active, st_ready, st_rx_tune, st_rx} rsf_state_t;
	typedef enum logic [3:0] {seq_idle, seq_por_arm, seq_por, seq_ldo, seq_xtal, seq_pll, seq_vco, seq_settle, seq_fe,
		seq_modem} rsf_seq_t;
	typedef enum logic [1:0] {src_state, src_irq, src_modem, src_level} rsf_frr_src_t;
endpackage : rsf_pkg
`default_nettype wire

// *** rsf_timer.sv ***
// Step timer of the power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module rsf_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic load,
	input wire logic [17:0] value,
	output logic done
);
	logic [17:0] cnt_q;

	// Loaded count runs down; done pulses in the cycle after the count is one, as it reaches zero
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 18'h00000;
			done <= 1'b0;
		end else if (ce) begin
			done <= !load && (cnt_q == 18'h00001);
			if (load) begin
				cnt_q <= value;
			end else if (cnt_q != 18'h00000) begin
				cnt_q <= cnt_q - 18'h00001;
			end
		end
	end
endmodule : rsf_timer
`default_nettype wire

// *** rsf_spi_slave.sv ***
// Serial interface shifter: mode 0, MSB first, oversampled by the system clock
`timescale 1ns/10ps
`default_nettype none
module rsf_spi_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sel_n_pin,
	input wire logic sclk_pin,
	input wire logic sdi_pin,
	input wire logic [7:0] tx_byte,
	output logic byte_stb,
	output logic [7:0] rx_byte,
	output logic sel_fall,
	output logic sel_rise,
	output logic sdo,
	output logic sdo_oe
);
	logic [1:0] sel_sy_q;
	logic [1:0] sclk_sy_q;
	logic [1:0] sdi_sy_q;
	logic sclk_prev_q;
	logic sel_prev_q;
	logic [2:0] bit_q;
	logic [7:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic sclk_rise;
	logic sclk_fall;

	// Pins pass two flops; edges are taken from the second stage only
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_sy_q <= 2'h3;
			sclk_sy_q <= 2'h0;
			sdi_sy_q <= 2'h0;
			sclk_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else if (ce) begin
			sel_sy_q <= {sel_sy_q[0], sel_n_pin};
			sclk_sy_q <= {sclk_sy_q[0], sclk_pin};
			sdi_sy_q <= {sdi_sy_q[0], sdi_pin};
			sclk_prev_q <= sclk_sy_q[1];
			sel_prev_q <= sel_sy_q[1];
		end
	end

	assign sclk_rise = sclk_sy_q[1] && !sclk_prev_q;
	assign sclk_fall = !sclk_sy_q[1] && sclk_prev_q;

	// Select edges become one-cycle pulses for the controller
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_fall <= 1'b0;
			sel_rise <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (ce) begin
			sel_fall <= sel_prev_q && !sel_sy_q[1];
			sel_rise <= !sel_prev_q && sel_sy_q[1];
			sdo_oe <= !sel_sy_q[1];
		end
	end

	// Receive on rising clock; a byte strobe follows every eighth bit
	always_ff @(posedge clk) begin
		if (rst) begin
			bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_byte <= 8'h00;
			byte_stb <= 1'b0;
		end else if (ce) begin
			byte_stb <= 1'b0;
			if (sel_sy_q[1]) begin
				bit_q <= 3'h0;
			end else if (sclk_rise) begin
				rx_sh_q <= {rx_sh_q[6:0], sdi_sy_q[1]};
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					byte_stb <= 1'b1;
					rx_byte <= {rx_sh_q[6:0], sdi_sy_q[1]};
				end
			end
		end
	end

	// Transmit on falling clock; a new byte is taken at each byte boundary
	always_ff @(posedge clk) begin
		if (rst) begin
			sdo <= 1'b0;
			tx_sh_q <= 8'h00;
		end else if (ce && !sel_sy_q[1] && sclk_fall) begin
			if (bit_q == 3'h0) begin
				sdo <= tx_byte[7];
				tx_sh_q <= {tx_byte[6:0], 1'b0};
			end else begin
				sdo <= tx_sh_q[7];
				tx_sh_q <= {tx_sh_q[6:0], 1'b0};
			end
		end
	end
endmodule : rsf_spi_slave
`default_nettype wire

// *** rsf_ctrl.sv ***
// Operating-state controller with fast readback registers
`timescale 1ns/10ps
`default_nettype none
`include "rsf_defines.svh"
module rsf_ctrl #(
	parameter int POR_CYCLES = `RSF_C_POR
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic shutdown_pin,
	input wire logic serial_select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic irq_event,
	input wire logic rx_done,
	input wire logic [7:0] modem_status,
	input wire logic [7:0] rx_level,
	output logic sdo,
	output logic sdo_oe,
	output logic interrupt_out_n,
	output var rsf_pkg::rsf_state_t state_q,
	output logic uninit_q,
	output logic ldo_en,
	output logic xtal_en,
	output logic pll_en,
	output logic vco_cal,
	output logic rx_fe_en,
	output logic modem_rx_en,
	output logic boot_osc_en,
	output logic wake_timer_en
);
	logic [1:0] sdn_sy_q;
	logic sdn_s;
	logic hard_rst;
	logic spi_rst;
	logic byte_stb;
	logic [7:0] rx_byte;
	logic sel_fall;
	logic sel_rise;
	logic exec;
	logic [1:0] byte_idx_q;
	logic [7:0] cmd_q;
	logic [7:0] p1_q;
	logic burst_q;
	logic [1:0] frr_idx_q;
	logic [1:0] frr_nxt;
	logic [2:0] frr_hit;
	logic [7:0] tx_q;
	logic [7:0] snap_q [4];
	logic [7:0] src_val [4];
	rsf_pkg::rsf_frr_src_t cfg_q [4];
	logic [7:0] cfg_rst;
	logic irq_q;
	logic irq_clr;
	logic [11:0] busy_q;
	rsf_pkg::rsf_seq_t seq_q;
	rsf_pkg::rsf_seq_t seq_d;
	rsf_pkg::rsf_state_t state_d;
	rsf_pkg::rsf_state_t target_q;
	rsf_pkg::rsf_state_t target_d;
	rsf_pkg::rsf_state_t next_q;
	rsf_pkg::rsf_state_t next_d;
	logic uninit_d;
	logic tmr_load_q;
	logic [17:0] tmr_val_q;
	logic tmr_done;
	logic [3:0] req;
	logic [3:0] nxt;

	// Codes 1 to 6 name the reachable states in enum order; bit 3 flags a valid code
	function automatic logic [3:0] decode_state(input logic [7:0] code);
		logic [3:0] r;
		r = 4'h0;
		if (code >= `RSF_SC_STANDBY && code <= `RSF_SC_RX) begin
			r = {1'b1, code[2:0]};
		end
		return r;
	endfunction : decode_state

	// Readback command to register index; bit 2 flags a hit
	function automatic logic [2:0] frr_decode(input logic [7:0] code);
		unique case (code)
			`RSF_CMD_FRR_A: return 3'h4;
			`RSF_CMD_FRR_B: return 3'h5;
			`RSF_CMD_FRR_C: return 3'h6;
			`RSF_CMD_FRR_D: return 3'h7;
			default: return 3'h0;
		endcase
	endfunction : frr_decode

	// Length of each sequencer step in clock cycles
	function automatic logic [17:0] step_cycles(input rsf_pkg::rsf_seq_t s);
		unique case (s)
			rsf_pkg::seq_por: return 18'(POR_CYCLES);
			rsf_pkg::seq_ldo: return `RSF_C_LDO;
			rsf_pkg::seq_xtal: return `RSF_C_XTAL;
			rsf_pkg::seq_pll: return `RSF_C_PLL;
			rsf_pkg::seq_vco: return `RSF_C_VCO;
			rsf_pkg::seq_settle: return `RSF_C_SETTLE;
			rsf_pkg::seq_fe: return `RSF_C_FE;
			rsf_pkg::seq_modem: return `RSF_C_MODEM;
			default: return 18'h00000;
		endcase
	endfunction : step_cycles

	// Shutdown pin is asynchronous to the core clock
	always_ff @(posedge clk) begin
		if (rst) begin
			sdn_sy_q <= 2'h0;
		end else if (ce) begin
			sdn_sy_q <= {sdn_sy_q[0], shutdown_pin};
		end
	end

	assign sdn_s = sdn_sy_q[1];
	assign hard_rst = rst || sdn_s;
	assign spi_rst = hard_rst || (state_q == rsf_pkg::st_shutdown);
	assign exec = sel_rise && (byte_idx_q != 2'h0);
	assign frr_nxt = frr_idx_q + 2'h1;
	assign frr_hit = frr_decode(rx_byte);
	assign irq_clr = byte_stb && (byte_idx_q == 2'h0) && (rx_byte == `RSF_CMD_INT_STATUS);
	assign cfg_rst = `RSF_FRR_CFG_RST;
	assign req = decode_state(p1_q);
	assign nxt = decode_state(p1_q);

	rsf_spi_slave u_spi (
		.clk(clk),
		.rst(spi_rst),
		.ce(ce),
		.sel_n_pin(serial_select_n),
		.sclk_pin(sclk),
		.sdi_pin(sdi),
		.tx_byte(tx_q),
		.byte_stb(byte_stb),
		.rx_byte(rx_byte),
		.sel_fall(sel_fall),
		.sel_rise(sel_rise),
		.sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	rsf_timer u_tmr (
		.clk(clk),
		.rst(hard_rst),
		.ce(ce),
		.load(tmr_load_q),
		.value(tmr_val_q),
		.done(tmr_done)
	);

	// Frame capture and reply byte; readback replies need no command-done poll
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			byte_idx_q <= 2'h0;
			cmd_q <= 8'h00;
			p1_q <= 8'h00;
			burst_q <= 1'b0;
			frr_idx_q <= 2'h0;
			tx_q <= 8'h00;
		end else if (ce) begin
			if (sel_fall) begin
				byte_idx_q <= 2'h0;
				burst_q <= 1'b0;
				tx_q <= 8'h00;
			end else if (byte_stb) begin
				if (byte_idx_q != 2'h3) begin
					byte_idx_q <= byte_idx_q + 2'h1;
				end
				if (byte_idx_q == 2'h0) begin
					cmd_q <= rx_byte;
					burst_q <= frr_hit[2];
					frr_idx_q <= frr_hit[1:0];
					if (frr_hit[2]) begin
						tx_q <= snap_q[frr_hit[1:0]];
					end else if (rx_byte == `RSF_CMD_READ_CTS) begin
						tx_q <= (busy_q == 12'h000) ? `RSF_CTS_READY : `RSF_CTS_BUSY;
					end else begin
						tx_q <= 8'h00;
					end
				end else if (burst_q) begin
					frr_idx_q <= frr_nxt;
					tx_q <= snap_q[frr_nxt];
				end
				if (byte_idx_q == 2'h1) begin
					p1_q <= rx_byte;
				end
			end
		end
	end

	// Source values offered to the readback snapshot
	always_comb begin
		src_val[0] = {5'h00, state_q};
		src_val[1] = {7'h00, irq_q};
		src_val[2] = modem_status;
		src_val[3] = rx_level;
	end

	// Snapshot only at select fall so a burst reads one coherent set
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			for (int i = 0; i < 4; i++) begin
				snap_q[i] <= 8'h00;
				cfg_q[i] <= rsf_pkg::rsf_frr_src_t'(cfg_rst[2*i +: 2]);
			end
		end else if (ce) begin
			if (sel_fall) begin
				for (int i = 0; i < 4; i++) begin
					snap_q[i] <= src_val[cfg_q[i]];
				end
			end
			if (exec && !uninit_q && cmd_q == `RSF_CMD_SET_FRR) begin
				cfg_q[p1_q[5:4]] <= rsf_pkg::rsf_frr_src_t'(p1_q[1:0]);
			end
		end
	end

	// Pending interrupt; a new event in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			irq_q <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else if (ce) begin
			irq_q <= irq_event || (irq_q && !irq_clr);
			interrupt_out_n <= !(irq_event || (irq_q && !irq_clr));
		end
	end

	// Command-done stays busy for a fixed time after each ordinary command
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			busy_q <= 12'h000;
		end else if (ce) begin
			if (exec && frr_decode(cmd_q) == 3'h0 && cmd_q != `RSF_CMD_READ_CTS) begin
				busy_q <= `RSF_C_CMD;
			end else if (busy_q != 12'h000) begin
				busy_q <= busy_q - 12'h001;
			end
		end
	end

	// Sequencer: the only place the operating state is decided
	always_comb begin
		seq_d = seq_q;
		state_d = state_q;
		target_d = target_q;
		next_d = next_q;
		uninit_d = uninit_q;
		unique case (seq_q)
			rsf_pkg::seq_por_arm: seq_d = rsf_pkg::seq_por;
			rsf_pkg::seq_por: begin
				if (tmr_done) begin
					seq_d = rsf_pkg::seq_idle;
					state_d = rsf_pkg::st_standby;
				end
			end
			rsf_pkg::seq_ldo: if (tmr_done) seq_d = rsf_pkg::seq_xtal;
			rsf_pkg::seq_xtal: begin
				if (tmr_done) begin
					seq_d = rsf_pkg::seq_pll;
					state_d = rsf_pkg::st_rx_tune;
				end
			end
			rsf_pkg::seq_pll: if (tmr_done) seq_d = rsf_pkg::seq_vco;
			rsf_pkg::seq_vco: if (tmr_done) seq_d = rsf_pkg::seq_settle;
			rsf_pkg::seq_settle: begin
				if (tmr_done) begin
					seq_d = (target_q == rsf_pkg::st_rx) ? rsf_pkg::seq_fe : rsf_pkg::seq_idle;
				end
			end
			rsf_pkg::seq_fe: if (tmr_done) seq_d = rsf_pkg::seq_modem;
			rsf_pkg::seq_modem: begin
				if (tmr_done) begin
					seq_d = rsf_pkg::seq_idle;
					state_d = rsf_pkg::st_rx;
				end
			end
			rsf_pkg::seq_idle: begin
				if (sel_fall && (state_q == rsf_pkg::st_standby || state_q == rsf_pkg::st_sleep)) begin
					state_d = rsf_pkg::st_spi_active;
				end
				if (state_q == rsf_pkg::st_rx && rx_done && next_q != rsf_pkg::st_rx) begin
					state_d = next_q;
				end
				if (exec && uninit_q && cmd_q == `RSF_CMD_POWER_UP) begin
					uninit_d = 1'b0;
				end
				if (exec && !uninit_q) begin
					if (cmd_q == `RSF_CMD_START_RX) begin
						target_d = rsf_pkg::st_rx;
						next_d = nxt[3] ? rsf_pkg::rsf_state_t'(nxt[2:0]) : rsf_pkg::st_rx;
					end
					if (cmd_q == `RSF_CMD_CHANGE_STATE && req[3]) begin
						target_d = rsf_pkg::rsf_state_t'(req[2:0]);
					end
					if (cmd_q == `RSF_CMD_START_RX || (cmd_q == `RSF_CMD_CHANGE_STATE && req[3])) begin
						if (target_d != rsf_pkg::st_rx && target_d != rsf_pkg::st_rx_tune) begin
							state_d = target_d;
						end else if (state_q == rsf_pkg::st_rx_tune) begin
							seq_d = (target_d == rsf_pkg::st_rx) ? rsf_pkg::seq_fe : rsf_pkg::seq_idle;
						end else if (state_q == rsf_pkg::st_ready) begin
							seq_d = rsf_pkg::seq_pll;
							state_d = rsf_pkg::st_rx_tune;
						end else if (state_q != rsf_pkg::st_rx) begin
							seq_d = rsf_pkg::seq_ldo;
						end
					end
				end
			end
			default: seq_d = rsf_pkg::seq_idle;
		endcase
	end

	// Sequencer registers; every step entry reloads the step timer
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			seq_q <= rsf_pkg::seq_por_arm;
			state_q <= rsf_pkg::st_shutdown;
			target_q <= rsf_pkg::st_rx;
			next_q <= rsf_pkg::st_rx;
			uninit_q <= 1'b1;
			tmr_load_q <= 1'b0;
			tmr_val_q <= 18'h00000;
		end else if (ce) begin
			seq_q <= seq_d;
			state_q <= state_d;
			target_q <= target_d;
			next_q <= next_d;
			uninit_q <= uninit_d;
			tmr_load_q <= (seq_d != seq_q);
			tmr_val_q <= step_cycles(seq_d);
		end
	end

	// Block enables follow state and step one cycle later
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			ldo_en <= 1'b0;
			xtal_en <= 1'b0;
			pll_en <= 1'b0;
			vco_cal <= 1'b0;
			rx_fe_en <= 1'b0;
			modem_rx_en <= 1'b0;
			boot_osc_en <= 1'b0;
			wake_timer_en <= 1'b0;
		end else if (ce) begin
			ldo_en <= state_q >= rsf_pkg::st_ready || seq_q >= rsf_pkg::seq_ldo;
			xtal_en <= state_q >= rsf_pkg::st_ready || seq_q >= rsf_pkg::seq_xtal;
			pll_en <= state_q >= rsf_pkg::st_rx_tune || seq_q >= rsf_pkg::seq_pll;
			vco_cal <= seq_q == rsf_pkg::seq_vco;
			rx_fe_en <= state_q == rsf_pkg::st_rx || seq_q >= rsf_pkg::seq_fe;
			modem_rx_en <= state_q == rsf_pkg::st_rx;
			boot_osc_en <= state_q >= rsf_pkg::st_spi_active;
			wake_timer_en <= state_q == rsf_pkg::st_sleep;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || sdn_s || !ce);

	frr_wrap_a: assert property ((ce && byte_stb && burst_q && byte_idx_q != 2'h0) |=>
		(frr_idx_q == 2'($past(frr_idx_q) + 2'h1)) && tx_q == snap_q[frr_idx_q]) else $error("readback index did not advance");
	snap_hold_a: assert property ((ce && !sel_fall) |=> $stable(snap_q[0]) && $stable(snap_q[3]))
		else $error("readback snapshot changed mid-frame");
	shutdown_force_a: assert property (@(posedge clk) disable iff (rst) sdn_s |=>
		(state_q == rsf_pkg::st_shutdown) && !sdo_oe) else $error("shutdown pin did not force shutdown");
	uninit_block_a: assert property ((ce && exec && uninit_q && seq_q == rsf_pkg::seq_idle &&
		state_q != rsf_pkg::st_rx) |=> $stable(state_q)) else $error("command acted before initialisation");
	spi_wake_a: assert property ((ce && sel_fall && seq_q == rsf_pkg::seq_idle &&
		state_q inside {rsf_pkg::st_standby, rsf_pkg::st_sleep}) |=> state_q == rsf_pkg::st_spi_active ##1 boot_osc_en)
		else $error("serial event did not wake to serial-active");
	// A running sequence was already commanded, so only an idle sequencer must hold serial-active
	spi_stay_a: assert property ((ce && state_q == rsf_pkg::st_spi_active && seq_q == rsf_pkg::seq_idle &&
		!exec) |=> state_q == rsf_pkg::st_spi_active) else $error("left serial-active without a command");
	irq_hold_a: assert property ((irq_q && !irq_clr) ##1 ce |-> !interrupt_out_n)
		else $error("interrupt released without a status read");
	ready_xtal_a: assert property ((ce && state_q == rsf_pkg::st_ready) |=> xtal_en && !pll_en)
		else $error("crystal off in ready");
	step_order_a: assert property ((ce && seq_q == rsf_pkg::seq_ldo && tmr_done) |=>
		seq_q == rsf_pkg::seq_xtal && tmr_load_q ##1 xtal_en) else $error("sequencer step out of order");
	rx_next_a: assert property ((ce && state_q == rsf_pkg::st_rx && seq_q == rsf_pkg::seq_idle && rx_done &&
		next_q != rsf_pkg::st_rx) |=> state_q == $past(next_q)) else $error("no return to next state after receive");
	sleep_timer_a: assert property ((ce && state_q == rsf_pkg::st_sleep) |=> wake_timer_en && !boot_osc_en)
		else $error("wake-up timer off in sleep");
endmodule : rsf_ctrl
`default_nettype wire

// *** rsf_host.sv ***
// Host-side serial interface model that drives the controller's select, clock and data pins
`timescale 1ns/10ps
`default_nettype none
module rsf_host (
	input wire logic clk,
	input wire logic sdo,
	input wire logic sdo_oe,
	output logic sel_n,
	output logic sclk,
	output logic sdi
);
	logic [7:0] rx [8];
	logic miso;
	// A released output reads high through the pull-up, never the last bit
	assign miso = sdo_oe ? sdo : 1'b1;
	// Idle bus: select high, clock low
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b1;
	end
	// One frame of n bytes, mode 0, MSB first, eight system clocks per half period
	task automatic xfer(input int n, input logic [7:0] b0, input logic [7:0] b1);
		logic [7:0] tx;
		@(negedge clk) sel_n <= 1'b0;
		repeat (8) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			tx = (i == 0) ? b0 : (i == 1) ? b1 : 8'hff;
			for (int j = 7; j >= 0; j--) begin
				sdi <= tx[j];
				repeat (8) @(negedge clk);
				sclk <= 1'b1;
				rx[i][j] = miso;
				repeat (8) @(negedge clk);
				sclk <= 1'b0;
			end
		end
		repeat (8) @(negedge clk);
		sel_n <= 1'b1;
		// Deselected data line toggles so a stale level is never mistaken for data
		sdi <= ~sdi;
		repeat (8) @(negedge clk);
	endtask : xfer
endmodule : rsf_host
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench of the radio state controller
`timescale 1ns/10ps
`default_nettype none
`include "rsf_defines.svh"
module testbench;
	logic clk, rst, shutdown_pin, irq_event, rx_done;
	logic [7:0] modem_status, rx_level;
	wire logic sel_n, sclk, sdi, sdo, sdo_oe, interrupt_out_n, uninit_q;
	wire logic ldo_en, xtal_en, pll_en, vco_cal, rx_fe_en, modem_rx_en, boot_osc_en, wake_timer_en;
	rsf_pkg::rsf_state_t state_q;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h04, 8'h03};
	logic [7:0] frr_cmd [4] = '{`RSF_CMD_FRR_A, `RSF_CMD_FRR_B, `RSF_CMD_FRR_C, `RSF_CMD_FRR_D};
	int c_pos [4] = '{3, 2, 1, 4};

	rsf_host host_u (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
	// Short power-on reset keeps the run brief
	rsf_ctrl #(.POR_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .ce(1'b1), .shutdown_pin(shutdown_pin),
		.serial_select_n(sel_n), .sclk(sclk), .sdi(sdi), .irq_event(irq_event), .rx_done(rx_done),
		.modem_status(modem_status), .rx_level(rx_level), .sdo(sdo), .sdo_oe(sdo_oe),
		.interrupt_out_n(interrupt_out_n), .state_q(state_q), .uninit_q(uninit_q), .ldo_en(ldo_en),
		.xtal_en(xtal_en), .pll_en(pll_en), .vco_cal(vco_cal), .rx_fe_en(rx_fe_en), .modem_rx_en(modem_rx_en),
		.boot_osc_en(boot_osc_en), .wake_timer_en(wake_timer_en));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cuts a hang short well beyond the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim;
		end
	end

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wait_st(input rsf_pkg::rsf_state_t s, input int lim);
		for (int n = 0; n < lim && state_q !== s; n++) @(negedge clk);
	endtask : wait_st

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Power-on reset, refusal while uninitialised, then initialisation
	task automatic t_por;
		cmp({5'h0, state_q}, 8'h00);
		rst <= 1'b0;
		wait_st(rsf_pkg::st_standby, 200);
		cmp({5'h0, state_q}, 8'h01);
		cmp({7'h0, uninit_q}, 8'h01);
		host_u.xfer(2, `RSF_CMD_START_RX, `RSF_SC_RX);
		repeat (50) @(negedge clk);
		cmp({7'h0, ldo_en}, 8'h00);
		host_u.xfer(1, `RSF_CMD_POWER_UP, 8'h00);
		repeat (10) @(negedge clk);
		cmp({7'h0, uninit_q}, 8'h00);
		cmp({5'h0, state_q}, 8'h03);
		cmp({7'h0, boot_osc_en}, 8'h01);
	endtask : t_por

	// State-change targets standby, sleep, ready and serial-active, wake-up of low-power states and command-done replies
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			host_u.xfer(2, `RSF_CMD_CHANGE_STATE, codes[i]);
			repeat (10) @(negedge clk);
			cmp({5'h0, state_q}, codes[i]);
			if (i == 1) cmp({7'h0, wake_timer_en}, 8'h01);
			if (i == 2) cmp({7'h0, xtal_en}, 8'h01);
			if (i < 2) begin
				host_u.xfer(2, `RSF_CMD_READ_CTS, 8'h00);
				cmp(host_u.rx[1], `RSF_CTS_BUSY);
				cmp({5'h0, state_q}, 8'h03);
				repeat (300) @(negedge clk);
				host_u.xfer(2, `RSF_CMD_READ_CTS, 8'h00);
				cmp(host_u.rx[1], `RSF_CTS_READY);
			end
		end
	endtask : t_modes

	// Burst with wrap, values frozen in a frame, every readback command
	task automatic t_frr;
		fork
			host_u.xfer(6, `RSF_CMD_FRR_C, 8'h00);
			begin
				repeat (100) @(negedge clk);
				modem_status <= 8'h11;
			end
		join
		cmp(host_u.rx[1], 8'h5a);
		cmp(host_u.rx[2], 8'hc3);
		cmp(host_u.rx[3], 8'h03);
		cmp(host_u.rx[5], 8'h5a);
		for (int i = 0; i < 4; i++) begin
			host_u.xfer(5, frr_cmd[i], 8'h00);
			cmp(host_u.rx[c_pos[i]], 8'h11);
		end
	endtask : t_frr

	// Interrupt survives readback reads and clears on a status read
	task automatic t_irq;
		irq_event <= 1'b1;
		@(negedge clk) irq_event <= 1'b0;
		repeat (3) @(negedge clk);
		cmp({7'h0, interrupt_out_n}, 8'h00);
		host_u.xfer(2, `RSF_CMD_FRR_A, 8'h00);
		cmp({7'h0, interrupt_out_n}, 8'h00);
		host_u.xfer(1, `RSF_CMD_INT_STATUS, 8'h00);
		repeat (5) @(negedge clk);
		cmp({7'h0, interrupt_out_n}, 8'h01);
	endtask : t_irq

	// Source selection: register A is pointed at the receive level, then read back
	task automatic t_cfg;
		host_u.xfer(2, `RSF_CMD_SET_FRR, 8'h03);
		host_u.xfer(2, `RSF_CMD_FRR_A, 8'h00);
		cmp(host_u.rx[1], 8'hc3);
	endtask : t_cfg

	// Automatic sequence into receive, its timing and step order, then the chosen next state
	task automatic t_rx(input logic [7:0] nxt, input int lo, input int hi);
		int n, tp, tv, tf;
		n = 8;
		tp = 0;
		tv = 0;
		tf = 0;
		host_u.xfer(2, `RSF_CMD_START_RX, nxt);
		while (state_q !== rsf_pkg::st_rx && n < 6000) begin
			@(negedge clk);
			n++;
			if (pll_en && tp == 0) tp = n;
			if (vco_cal && tv == 0) tv = n;
			if (rx_fe_en && tf == 0) tf = n;
		end
		cmp({7'h0, n >= lo && n <= hi}, 8'h01);
		cmp({7'h0, tp < tv && tv < tf}, 8'h01);
		repeat (3) @(negedge clk);
		cmp({7'h0, tp < tf && ldo_en && xtal_en && modem_rx_en}, 8'h01);
		rx_done <= 1'b1;
		@(negedge clk) rx_done <= 1'b0;
		repeat (8) @(negedge clk);
		cmp({5'h0, state_q}, nxt);
	endtask : t_rx

	// Shutdown pin forces shutdown; release reruns power-on reset
	task automatic t_sdn;
		shutdown_pin <= 1'b1;
		repeat (120) @(negedge clk);
		cmp({5'h0, state_q}, 8'h00);
		cmp({7'h0, sdo_oe}, 8'h00);
		shutdown_pin <= 1'b0;
		wait_st(rsf_pkg::st_standby, 200);
		cmp({6'h0, state_q == rsf_pkg::st_standby, uninit_q}, 8'h03);
		// Source selection was lost, so register A shows the state again
		host_u.xfer(2, `RSF_CMD_FRR_A, 8'h00);
		cmp(host_u.rx[1], 8'h01);
	endtask : t_sdn

	// Main sequence
	initial begin
		rst = 1'b1;
		shutdown_pin = 1'b0;
		irq_event = 1'b0;
		rx_done = 1'b0;
		modem_status = 8'h5a;
		rx_level = 8'hc3;
		repeat (6) @(negedge clk);
		t_por;
		t_modes;
		t_frr;
		t_irq;
		t_cfg;
		host_u.xfer(2, `RSF_CMD_CHANGE_STATE, `RSF_SC_STANDBY);
		repeat (300) @(negedge clk);
		t_rx(`RSF_SC_READY, 4000, 4800);
		t_rx(`RSF_SC_STANDBY, 1100, 1400);
		t_sdn;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
